// ### bench/dpwm_load_model.sv
// Load model on one modulator pin: tallies high cycles and level changes
`timescale 1ns/1ns
module dpwm_load_model (
	// Clock and window control
	input wire logic sys_clk_in,
	input wire logic clear_in,
	// Pin under observation
	input wire logic pin_in,
	// Tallies over the current window
	output logic [15:0] high_count_out,
	output logic [15:0] edge_count_out
);
	logic last_pin = 1'b0; // Previous pin level, for change detection

	// Tally once per edge; clear opens a fresh window of known length
	always @(posedge sys_clk_in) begin
		if (clear_in) begin
			high_count_out <= 16'h0000;
			edge_count_out <= 16'h0000;
		end else begin
			high_count_out <= high_count_out + {15'h0, pin_in};
			// Case inequality so an unknown pin shows up as a change
			edge_count_out <= edge_count_out + {15'h0, pin_in !== last_pin};
		end
		last_pin <= pin_in;
	end
endmodule

// ### bench/tb.sv
// Self-checking bench for the dual pulse-width modulator
`timescale 1ns/1ns
module tb;
	import dpwm_pkg::*;
	// Stimulus, all valid from time zero
	logic sys_clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [7:0] addr = 8'h00;
	logic [7:0] wdata = 8'h00;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic clr = 1'b1;
	// Observed outputs and load tallies
	logic [7:0] rdata;
	logic pin_a;
	logic pin_b;
	logic [15:0] hi_a, hi_b, tr_a, tr_b;
	int err_total = 0;
	int check_count = 0;
	// One table row: register bytes beside the tallies they should give over one period
	typedef struct packed {
		logic [7:0] ctrl; // Control byte
		logic [7:0] da;   // Duty byte, first channel
		logic [7:0] db;   // Duty byte, second channel
		logic [15:0] per; // Period in clocks
		logic [15:0] ha;  // High clocks per period, first channel
		logic [15:0] hb;  // High clocks per period, second channel
		logic [7:0] ta;   // Level changes per period, first channel
		logic [7:0] tb;   // Level changes per period, second channel
	} dpwm_row_s;
	dpwm_row_s rows [5] = '{
		'{8'hC3, 8'h40, 8'hFF, 16'h00FF, 16'h0040, 16'h00FF, 8'h02, 8'h00},
		'{8'h0D, 8'hE5, 8'h1F, 16'h007C, 16'h0014, 16'h0000, 8'h02, 8'h00},
		'{8'h46, 8'hFF, 8'h41, 16'h007E, 16'h0000, 16'h0002, 8'h00, 8'h02},
		'{8'hBF, 8'h81, 8'h00, 16'h07F0, 16'h0010, 16'h0000, 8'h02, 8'h00},
		'{8'h3C, 8'h10, 8'h10, 16'h01F0, 16'h0000, 16'h0000, 8'h00, 8'h00}};

	dpwm_top dut (.sys_clk_in(sys_clk_in), .srst_in(srst_in), .sfr_addr_in(addr),
		.sfr_wdata_in(wdata), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_rdata_out(rdata),
		.pulse_out_a_out(pin_a), .pulse_out_b_out(pin_b));
	dpwm_load_model load_a (.sys_clk_in(sys_clk_in), .clear_in(clr), .pin_in(pin_a),
		.high_count_out(hi_a), .edge_count_out(tr_a));
	dpwm_load_model load_b (.sys_clk_in(sys_clk_in), .clear_in(clr), .pin_in(pin_b),
		.high_count_out(hi_b), .edge_count_out(tr_b));

	// 100 MHz clock
	initial begin
		forever #5 sys_clk_in = ~sys_clk_in;
	end

	// Compare tasks, one per result width
	task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic chk16(input string what, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %s expected %0d seen %0d", what, exp, got);
		end
	endtask

	// Register access; entered and left 1 ns after an edge
	// One idle edge after each write, so a following strobe never restarts in the same step
	task automatic sfr_write(input logic [7:0] a, input logic [7:0] d);
		addr = a;
		wdata = d;
		wr = 1'b1;
		@(posedge sys_clk_in);
		#1 wr = 1'b0;
		@(posedge sys_clk_in);
		#1;
	endtask
	task automatic sfr_check(input logic [7:0] a, input logic [7:0] exp);
		addr = a;
		rd = 1'b1;
		@(posedge sys_clk_in);
		#1 rd = 1'b0;
		@(posedge sys_clk_in);
		#1 chk8("read data", exp, rdata);
	endtask

	// Clear both tallies, then let n edges count
	task automatic window(input int n);
		clr = 1'b1;
		@(posedge sys_clk_in);
		#1 clr = 1'b0;
		repeat (n) @(posedge sys_clk_in);
		#1;
	endtask

	task automatic finish_test();
		if (err_total == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask

	// Watchdog, well past the expected run of a few thousand cycles
	initial begin
		#500000;
		err_total++;
		finish_test();
	end

	initial begin
		repeat (8) @(posedge sys_clk_in);
		#1 srst_in = 1'b0;
		chk8("pins after reset", 8'h00, {6'h00, pin_a, pin_b});
		// Table: one shared period, two duties, every width code
		foreach (rows[i]) begin
			sfr_write(DPWM_ADDR_CTRL, rows[i].ctrl);
			sfr_write(DPWM_ADDR_DUTY_A, rows[i].da);
			sfr_write(DPWM_ADDR_DUTY_B, rows[i].db);
			sfr_check(DPWM_ADDR_CTRL, rows[i].ctrl);
			sfr_check(DPWM_ADDR_DUTY_A, rows[i].da);
			sfr_check(DPWM_ADDR_DUTY_B, rows[i].db);
			window(rows[i].per);
			chk16("high a", rows[i].ha, hi_a);
			chk16("high b", rows[i].hb, hi_b);
			chk16("changes a", {8'h00, rows[i].ta}, tr_a);
			chk16("changes b", {8'h00, rows[i].tb}, tr_b);
		end
		// Unmapped write ignored, unmapped read gives zero
		sfr_write(8'hB3, 8'hFF);
		sfr_check(8'hB3, DPWM_UNMAPPED_VAL);
		sfr_check(DPWM_ADDR_CTRL, 8'h3C);
		// Duty write acts at once, not at the period boundary
		sfr_write(DPWM_ADDR_CTRL, 8'h01);
		sfr_write(DPWM_ADDR_DUTY_A, 8'h00);
		repeat (40) @(posedge sys_clk_in);
		#1 chk8("pin a before write", 8'h00, {7'h00, pin_a});
		// Write lands at the first edge, pin follows at the next one
		sfr_write(DPWM_ADDR_DUTY_A, 8'h1F);
		chk8("pin a after write", 8'h01, {7'h00, pin_a});
		// Mid-period change lands between old and new duty
		sfr_write(DPWM_ADDR_DUTY_A, 8'h08);
		repeat (40) @(posedge sys_clk_in);
		// Window of exactly 31 clocks: 9, two for the write, then 20
		#1 window(9);
		sfr_write(DPWM_ADDR_DUTY_A, 8'h18);
		repeat (20) @(posedge sys_clk_in);
		#1 chk16("mixed period in range", 16'h1, {15'h0, hi_a >= 8 && hi_a <= 24});
		chk16("mixed period changes", 16'h1, {15'h0, tr_a <= 4});
		// Second reset mid-run clears registers and pins
		srst_in = 1'b1;
		repeat (2) @(posedge sys_clk_in);
		#1 srst_in = 1'b0;
		chk8("pins after reset", 8'h00, {6'h00, pin_a, pin_b});
		sfr_check(DPWM_ADDR_CTRL, DPWM_RESET_VAL);
		sfr_check(DPWM_ADDR_DUTY_A, DPWM_RESET_VAL);
		sfr_check(DPWM_ADDR_DUTY_B, DPWM_RESET_VAL);
		finish_test();
	end
endmodule

// ### common/dpwm_pkg.sv
// Shared constants, types and decode helpers for the dual pulse-width modulator
package dpwm_pkg;

	// Special function register addresses
	localparam logic [7:0] DPWM_ADDR_CTRL = 8'hB2;
	localparam logic [7:0] DPWM_ADDR_DUTY_A = 8'hA1;
	localparam logic [7:0] DPWM_ADDR_DUTY_B = 8'hA2;

	// Reset values and read value of unmapped addresses
	localparam logic [7:0] DPWM_RESET_VAL = 8'h00;
	localparam logic [7:0] DPWM_UNMAPPED_VAL = 8'h00;

	// Channel count and data width
	localparam int DPWM_CH = 2;
	localparam int DPWM_W = 8;

	// Resolution codes
	localparam logic [1:0] DPWM_RES_5 = 2'h0;
	localparam logic [1:0] DPWM_RES_6 = 2'h1;
	localparam logic [1:0] DPWM_RES_7 = 2'h2;
	localparam logic [1:0] DPWM_RES_8 = 2'h3;

	// Full-scale divisors (2^n - 1) per resolution
	localparam logic [7:0] DPWM_FS_5 = 8'h1F;
	localparam logic [7:0] DPWM_FS_6 = 8'h3F;
	localparam logic [7:0] DPWM_FS_7 = 8'h7F;
	localparam logic [7:0] DPWM_FS_8 = 8'hFF;

	// Control register layout, MSB first
	typedef struct packed {
		logic [1:0] res;      // Counter width select
		logic [3:0] prescale; // Core clocks per count, minus one
		logic en_b;           // Second channel enable
		logic en_a;           // First channel enable
	} dpwm_ctrl_s;

	// Full scale of the counter; also the duty mask
	function automatic logic [7:0] dpwm_full_scale(input logic [1:0] res);
		logic [7:0] fs;
		fs = DPWM_FS_8;
		case (res)
			DPWM_RES_5: fs = DPWM_FS_5;
			DPWM_RES_6: fs = DPWM_FS_6;
			DPWM_RES_7: fs = DPWM_FS_7;
			default: fs = DPWM_FS_8;
		endcase
		return fs;
	endfunction

endpackage

// ### design/dpwm_period_counter.sv
// Shared prescaler and period counter for both modulator channels
`timescale 1ns/1ns
module dpwm_period_counter
	import dpwm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// Configuration
	input wire dpwm_ctrl_s ctrl_in,
	// Counter state
	output logic [7:0] count_out,
	output logic wrap_out
);

	logic [3:0] pre_reg;  // Prescale divider
	logic [3:0] pre_next;
	logic [7:0] cnt_reg;  // Period position
	logic [7:0] cnt_next;
	logic [7:0] full;     // Current full scale
	logic tick;           // One-cycle count enable
	logic wrap;           // Last count of a period

	// Next-state logic for prescaler and counter
	always_comb begin
		full = dpwm_full_scale(ctrl_in.res);
		// Compare with >= so a lowered prescale cannot strand the divider
		tick = (pre_reg >= ctrl_in.prescale);
		pre_next = tick ? 4'h0 : 4'(pre_reg + 4'h1);
		cnt_next = cnt_reg;
		wrap = 1'b0;
		if (cnt_reg > 8'(full - 8'h01)) begin
			// Width just shrank: restart at once instead of running off range
			cnt_next = 8'h00;
		end else if (tick) begin
			if (cnt_reg == 8'(full - 8'h01)) begin
				cnt_next = 8'h00; // Full scale values per period
				wrap = 1'b1;
			end else begin
				cnt_next = 8'(cnt_reg + 8'h01);
			end
		end
	end

	// Registers only
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			pre_reg <= 4'h0;
			cnt_reg <= DPWM_RESET_VAL;
		end else begin
			pre_reg <= pre_next;
			cnt_reg <= cnt_next;
		end
	end

	assign count_out = cnt_reg;
	assign wrap_out = wrap;

	// Helper state for checking the period length
	logic [11:0] since_reg;    // Cycles since last wrap
	logic chg_reg;             // Configuration moved during this period
	logic seen_reg;            // At least one wrap seen
	dpwm_ctrl_s prev_reg;      // Configuration one cycle ago
	logic [11:0] exp_len;      // Expected period length in cycles

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			since_reg <= 12'h000;
			chg_reg <= 1'b0;
			seen_reg <= 1'b0;
			prev_reg <= '0;
		end else begin
			since_reg <= wrap ? 12'h000 : 12'(since_reg + 12'h001);
			chg_reg <= wrap ? 1'b0 : (chg_reg | (ctrl_in != prev_reg));
			seen_reg <= seen_reg | wrap;
			prev_reg <= ctrl_in;
		end
	end

	assign exp_len = 12'({4'h0, full} * (12'({8'h00, ctrl_in.prescale}) + 12'h001));

	// Period is (2^n - 1) * (prescale + 1) cycles when undisturbed
	property p_period_len;
		@(posedge sys_clk_in) disable iff (srst_in)
		(wrap && seen_reg && !chg_reg && ctrl_in == prev_reg)
			|-> (since_reg == 12'(exp_len - 12'h001));
	endproperty
	a_period_len: assert property (p_period_len)
		else $error("period length differs from full scale times prescale");

	property p_cover_slow;
		@(posedge sys_clk_in) disable iff (srst_in)
		wrap && ctrl_in.prescale == 4'hF && ctrl_in.res == DPWM_RES_8;
	endproperty
	c_cover_slow: cover property (p_cover_slow);

endmodule

// ### design/dpwm_top.sv
// Dual pulse-width modulator with its three special function registers
//
// Functional notes
// - Two channels share period, separate duty registers
// - Control bits 7:6 select 5 to 8 bits
// - Period equals (2^n-1) times (prescale+1) clocks
// - Duty is low n bits over 2^n-1
// - Duty write takes effect without waiting period
// - Changed period shows duty between old and new
// - Control bit 1 enables second channel output
// - Control bit 0 enables first channel output
`timescale 1ns/1ns
module dpwm_top
	import dpwm_pkg::*;
(
	// Clock and reset
	input wire logic sys_clk_in,
	input wire logic srst_in,
	// Special function register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic [7:0] sfr_wdata_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	output logic [7:0] sfr_rdata_out,
	// Port pin outputs
	output logic pulse_out_a_out,
	output logic pulse_out_b_out
);

	dpwm_ctrl_s ctrl_reg;                 // Shared control register
	dpwm_ctrl_s ctrl_next;
	logic [7:0] duty_reg [DPWM_CH];       // Per-channel duty registers
	logic [7:0] duty_next [DPWM_CH];
	logic [DPWM_CH-1:0] pulse_reg;        // Registered pin levels
	logic [DPWM_CH-1:0] pulse_next;
	logic [DPWM_CH-1:0] chan_en;          // Channel enables as a vector
	logic [7:0] rdata_reg;                // Read data holding register
	logic [7:0] rdata_next;
	logic [7:0] count;                    // Shared period position
	logic wrap;                           // Period boundary pulse
	logic [7:0] full;                     // Full scale and duty mask
	logic wr_ctrl;                        // Write strobes per register
	logic wr_a;
	logic wr_b;

	// One counter serves both channels, so they stay phase aligned
	dpwm_period_counter u_counter (
		.sys_clk_in(sys_clk_in),
		.srst_in(srst_in),
		.ctrl_in(ctrl_reg),
		.count_out(count),
		.wrap_out(wrap)
	);

	// Address decode of write strobes
	always_comb begin
		wr_ctrl = 1'b0;
		wr_a = 1'b0;
		wr_b = 1'b0;
		if (sfr_addr_in == DPWM_ADDR_CTRL) begin
			wr_ctrl = sfr_wr_in;
		end else if (sfr_addr_in == DPWM_ADDR_DUTY_A) begin
			wr_a = sfr_wr_in;
		end else if (sfr_addr_in == DPWM_ADDR_DUTY_B) begin
			wr_b = sfr_wr_in;
		end
	end

	// Register file next values and read mux
	always_comb begin
		ctrl_next = ctrl_reg;
		duty_next[0] = duty_reg[0];
		duty_next[1] = duty_reg[1];
		rdata_next = rdata_reg;
		// Full byte stored; resolution field sets the counter width
		if (wr_ctrl) begin
			ctrl_next = dpwm_ctrl_s'(sfr_wdata_in);
		end
		// Independent duty values per channel
		if (wr_a) begin
			duty_next[0] = sfr_wdata_in;
		end
		if (wr_b) begin
			duty_next[1] = sfr_wdata_in;
		end
		// Read data held until the next read
		if (sfr_rd_in) begin
			if (sfr_addr_in == DPWM_ADDR_CTRL) begin
				rdata_next = ctrl_reg;
			end else if (sfr_addr_in == DPWM_ADDR_DUTY_A) begin
				rdata_next = duty_reg[0];
			end else if (sfr_addr_in == DPWM_ADDR_DUTY_B) begin
				rdata_next = duty_reg[1];
			end else begin
				rdata_next = DPWM_UNMAPPED_VAL;
			end
		end
	end

	// Register file flip-flops
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			ctrl_reg <= dpwm_ctrl_s'(DPWM_RESET_VAL);
			duty_reg[0] <= DPWM_RESET_VAL;
			duty_reg[1] <= DPWM_RESET_VAL;
			rdata_reg <= DPWM_RESET_VAL;
		end else begin
			ctrl_reg <= ctrl_next;
			duty_reg[0] <= duty_next[0];
			duty_reg[1] <= duty_next[1];
			rdata_reg <= rdata_next;
		end
	end

	assign full = dpwm_full_scale(ctrl_reg.res);
	assign chan_en = {ctrl_reg.en_b, ctrl_reg.en_a};

	// Per-channel comparator against the live duty register
	genvar g;
	generate
		for (g = 0; g < DPWM_CH; g++) begin : g_chan
			// Masking drops unused upper duty bits
			// No shadow copy, so a write acts mid-period
			// Disabled channels held low
			assign pulse_next[g] = chan_en[g] && (count < (duty_reg[g] & full));
		end
	endgenerate

	// Output flip-flops; one cycle of latency, but glitch-free pins
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			pulse_reg <= '0;
		end else begin
			pulse_reg <= pulse_next;
		end
	end

	assign pulse_out_a_out = pulse_reg[0];
	assign pulse_out_b_out = pulse_reg[1];
	assign sfr_rdata_out = rdata_reg;

	// Checks
	default clocking cb @(posedge sys_clk_in);
	endclocking
	default disable iff (srst_in);

	property p_shared;
		(chan_en == 2'h3 && duty_reg[0] == duty_reg[1]) |=>
			(pulse_out_a_out == pulse_out_b_out);
	endproperty
	a_shared: assert property (p_shared)
		else $error("channels with equal duty differ");

	property p_count_range;
		$stable(ctrl_reg.res) |-> (count < full);
	endproperty
	a_count_range: assert property (p_count_range)
		else $error("counter beyond selected width");

	property p_duty_full;
		(ctrl_reg.en_a && (duty_reg[0] & full) == full) [*2] |-> pulse_out_a_out;
	endproperty
	a_duty_full: assert property (p_duty_full)
		else $error("full scale duty not constantly high");

	property p_duty_zero;
		((duty_reg[1] & full) == 8'h00) |=> !pulse_out_b_out;
	endproperty
	a_duty_zero: assert property (p_duty_zero)
		else $error("zero duty produced a high level");

	property p_write_now;
		(wr_a && !wr_ctrl) ##1 !wr_ctrl |-> ##1
			(pulse_out_a_out == ($past(ctrl_reg.en_a) &&
				($past(count) < ($past(sfr_wdata_in, 2) & $past(full)))));
	endproperty
	a_write_now: assert property (p_write_now)
		else $error("duty write not applied within two cycles");

	property p_between;
		pulse_out_b_out |-> ($past(count) < ($past(duty_reg[1]) & $past(full)));
	endproperty
	a_between: assert property (p_between)
		else $error("high level while count not below duty");

	property p_off_b;
		!ctrl_reg.en_b |=> !pulse_out_b_out;
	endproperty
	a_off_b: assert property (p_off_b)
		else $error("disabled second channel drives high");

	property p_off_a;
		!ctrl_reg.en_a |=> !pulse_out_a_out;
	endproperty
	a_off_a: assert property (p_off_a)
		else $error("disabled first channel drives high");

	property p_compare;
		(ctrl_reg.en_a && count < (duty_reg[0] & full)) |=> pulse_out_a_out ##0
			$past(count) < $past(duty_reg[0] & full);
	endproperty
	a_compare: assert property (p_compare)
		else $error("enabled channel low while count below duty");

	property p_cov_mid_write;
		ctrl_reg.en_a && wr_a && count != 8'h00;
	endproperty
	c_cov_mid_write: cover property (p_cov_mid_write);

	property p_cov_both;
		pulse_out_a_out && !pulse_out_b_out && chan_en == 2'h3;
	endproperty
	c_cov_both: cover property (p_cov_both);

	property p_cov_wrap5;
		wrap && ctrl_reg.res == DPWM_RES_5;
	endproperty
	c_cov_wrap5: cover property (p_cov_wrap5);

endmodule
